//--- design/vstat_pkg.sv
// package for the video status and write monitor block
// assumes a host I/O bus with byte data and 16-bit port addresses
package vstat_pkg;
   localparam logic [15:0] ADDR_VIDEO_SIGNAL_STATUS = 16'h03DA;
   localparam logic [15:0] ADDR_MIRROR_WRITE_STATUS = 16'h03DD;
   localparam logic [15:0] ADDR_CAPTURED_WRITE_BYTE = 16'h03DE;
   localparam logic [15:0] ADDR_CTRL_INDEX = 16'h03D4;
   localparam logic [15:0] ADDR_CTRL_DATA = 16'h03D5;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] PEN_UNDEFINED = 2'h0;

   // live video levels, 1 = active
   typedef struct packed {
      logic intensity;
      logic red;
      logic green;
      logic blue;
      logic vsync;
      logic blank;
   } video_levels_s;

   // control bits mirrored into the second status register
   typedef struct packed {
      logic display_enable_mirror;
      logic enable_gate_mirror;
      logic mode_sel2_mirror;
      logic mode_sel1_mirror;
      logic mode_sel0_mirror;
   } ctrl_mirror_s;

   // one host I/O cycle, strobes are one-cycle pulses
   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } io_req_s;
endpackage : vstat_pkg

//--- design/video_status_write_monitor.sv
// read-only status ports of the video adapter and the display_controller write monitor
// assumes one-cycle read and write strobes synchronous to CLK_IN, never both at once
//
// Contract
// RQ1: bits 7..4 of the first status register read the intensity, red, green and blue levels.
// RQ2: bit 3 of the first status register reads 1 while vertical sync is active.
// RQ3: bits 2..1 of the first status register are the unsupported pen bits, value undefined.
// RQ4: bit 0 of the first status register inverts on every read of that register.
// RQ5: bit 7 of the second status register reads 1 while video is blanking.
// RQ6: bit 6 of the second status register reads the display enable control bit.
// RQ7: bit 5 of the second status register reads the enable gate control bit.
// RQ8: bits 4..2 of the second status register read mode select bits 2, 1 and 0.
// RQ9: a host write to either display_controller port sets the write flag.
// RQ10: reading the captured byte clears the write flag until the next controller write.
// RQ11: bit 0 of the second status register shows the last controller port written, 1 = data.
// RQ12: the captured byte register holds the byte of the last controller port write.
// RQ13: reset clears the write flag, last port flag, retrace toggle and captured byte.
`timescale 1ns/1ns
module video_status_write_monitor (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // host I/O bus
   input wire vstat_pkg::io_req_s IO_REQ_IN,
   output logic [7:0] IO_RDATA_OUT,
   output logic IO_RVALID_OUT,
   // live video and control levels
   input wire vstat_pkg::video_levels_s VIDEO_IN,
   input wire vstat_pkg::ctrl_mirror_s CTRL_IN
);
   import vstat_pkg::*;

   logic write_flag_r;
   logic write_flag_nxt;
   logic last_port_r;
   logic last_port_nxt;
   logic retrace_r;
   logic retrace_nxt;
   logic [7:0] capt_r;
   logic [7:0] capt_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;

   wire sel_a = IO_REQ_IN.addr == ADDR_VIDEO_SIGNAL_STATUS;
   wire sel_b = IO_REQ_IN.addr == ADDR_MIRROR_WRITE_STATUS;
   wire sel_c = IO_REQ_IN.addr == ADDR_CAPTURED_WRITE_BYTE;
   wire sel_idx = IO_REQ_IN.addr == ADDR_CTRL_INDEX;
   wire sel_dat = IO_REQ_IN.addr == ADDR_CTRL_DATA;
   wire rd_a = IO_REQ_IN.rd && sel_a;
   wire rd_b = IO_REQ_IN.rd && sel_b;
   wire rd_c = IO_REQ_IN.rd && sel_c;
   wire rd_any = rd_a || rd_b || rd_c;
   wire ctl_wr = IO_REQ_IN.wr && (sel_idx || sel_dat);

   // RQ1 RQ2 RQ3 RQ4 first status byte
   wire [7:0] stat_a = {VIDEO_IN.intensity, VIDEO_IN.red, VIDEO_IN.green, VIDEO_IN.blue,
                        VIDEO_IN.vsync, PEN_UNDEFINED, retrace_r};
   // RQ5 RQ6 RQ7 RQ8 RQ11 second status byte
   wire [7:0] stat_b = {VIDEO_IN.blank, CTRL_IN.display_enable_mirror,
                        CTRL_IN.enable_gate_mirror, CTRL_IN.mode_sel2_mirror,
                        CTRL_IN.mode_sel1_mirror, CTRL_IN.mode_sel0_mirror,
                        write_flag_r, last_port_r};

   // RQ4 flips after each read of the first status register, so every other such read sees retrace
   assign retrace_nxt = rd_a ? ~retrace_r : retrace_r;
   // RQ9 RQ10 set beats clear when a write and a read coincide
   assign write_flag_nxt = ctl_wr ? 1'b1 : (rd_c ? 1'b0 : write_flag_r);
   // RQ11 last port written
   assign last_port_nxt = ctl_wr ? sel_dat : last_port_r;
   // RQ12 capture full byte
   assign capt_nxt = ctl_wr ? IO_REQ_IN.wdata : capt_r;
   // unmapped reads return zero
   assign rdata_nxt = rd_a ? stat_a :
                      rd_b ? stat_b :
                      rd_c ? capt_r : RESET_BYTE;

   // RQ13 reset clears the monitor state
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         write_flag_r <= 1'b0;
         last_port_r <= 1'b0;
         retrace_r <= 1'b0;
         capt_r <= RESET_BYTE;
         rdata_r <= RESET_BYTE;
         rvalid_r <= 1'b0;
      end else begin
         write_flag_r <= write_flag_nxt;
         last_port_r <= last_port_nxt;
         retrace_r <= retrace_nxt;
         capt_r <= capt_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= IO_REQ_IN.rd;
      end
   end

   assign IO_RDATA_OUT = rdata_r;
   assign IO_RVALID_OUT = rvalid_r;

   // RQ4 after a read the retrace toggle differs from the retrace bit that read returned
   a_retrace_toggles: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      rd_a |=> (IO_RDATA_OUT[0] != retrace_r)) else $error("retrace did not flip"); // RQ4
   // RQ9 write sets flag
   a_write_sets_flag: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      ctl_wr |=> write_flag_r) else $error("write flag not set"); // RQ9
   // RQ10 read clears flag
   a_read_clears_flag: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (rd_c && !ctl_wr) |=> !write_flag_r) else $error("write flag not cleared"); // RQ10
   // RQ10 flag cannot rise without a write
   a_flag_needs_write: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      $rose(write_flag_r) |-> $past(ctl_wr)) else $error("flag rose without write"); // RQ10
   // RQ11 port flag follows address
   a_last_port: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      ctl_wr |=> (last_port_r == $past(sel_dat))) else $error("port flag wrong"); // RQ11
   // RQ12 captured byte readback
   a_capture_back: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      ctl_wr ##1 (rd_c && !ctl_wr) |=> (IO_RDATA_OUT == $past(IO_REQ_IN.wdata, 2)))
      else $error("captured byte mismatch"); // RQ12
   // RQ1 RQ2 video levels
   a_video_bits: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      rd_a |=> (IO_RDATA_OUT[7:3] == $past({VIDEO_IN.intensity, VIDEO_IN.red,
      VIDEO_IN.green, VIDEO_IN.blue, VIDEO_IN.vsync}))) else $error("video bits wrong"); // RQ1
   // RQ5 RQ6 RQ7 RQ8 mirror bits
   a_mirror_bits: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      rd_b |=> (IO_RDATA_OUT[7:2] == $past({VIDEO_IN.blank, CTRL_IN})))
      else $error("mirror bits wrong"); // RQ8
   // RQ13 reset state
   a_reset_clear: assert property (@(posedge CLK_IN)
      !NRST_IN |=> (!write_flag_r && !last_port_r && !retrace_r && capt_r == RESET_BYTE))
      else $error("reset state wrong"); // RQ13
endmodule : video_status_write_monitor

//--- tb/vstat_host.sv
// host processor model issuing single I/O port cycles
// assumes the bench calls io_cycle from one process at a time
`timescale 1ns/1ns
module vstat_host (
   // clock
   input wire logic clk_in,
   // host I/O request
   output vstat_pkg::io_req_s req_out
);
   import vstat_pkg::*;
   initial req_out = '0;
   // strobe held for one edge, then the whole request is released
   task automatic io_cycle(input logic [15:0] a, input logic rd, input logic [7:0] d);
      @(posedge clk_in);
      req_out <= '{addr: a, rd: rd, wr: !rd, wdata: d};
      @(posedge clk_in);
      req_out <= '0;
   endtask : io_cycle
endmodule : vstat_host

//--- tb/video_status_write_monitor_tb_top.sv
// random host reads and writes against an integer model of the status ports
// assumes the host model in vstat_host.sv
`timescale 1ns/1ns
module video_status_write_monitor_tb_top;
   import vstat_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   io_req_s req;
   video_levels_s vid = '0;
   ctrl_mirror_s ctl = '0;
   logic [7:0] rdata;
   logic rvalid;
   int bad_count = 0;
   int n_tests = 0;
   int flag = 0, lastp = 0, cap = 0, retr = 0;
   logic [15:0] pa [7] = '{16'h03D4, 16'h03D5, 16'h03DA, 16'h03DD, 16'h03DE, 16'h03DB, 16'h03D9};
   always #5 clk = ~clk;
   vstat_host u_vstat_host (.clk_in(clk), .req_out(req));
   video_status_write_monitor u_video_status_write_monitor (.CLK_IN(clk), .NRST_IN(nrst),
      .IO_REQ_IN(req), .IO_RDATA_OUT(rdata), .IO_RVALID_OUT(rvalid),
      .VIDEO_IN(vid), .CTRL_IN(ctl));
   task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", w, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #40000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      logic [15:0] a;
      logic rd;
      logic [7:0] d, exp;
      video_levels_s vv;
      ctrl_mirror_s cc;
      void'($urandom(32'h6A59CFCA));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      // includes writes to read-only ports and reads of unmapped ports
      for (int i = 0; i < 400; i++) begin
         // mid-run reset must clear flag, port, retrace and captured byte
         if (i == 200) begin
            nrst <= 1'b0;
            repeat (3) @(posedge clk);
            nrst <= 1'b1;
            flag = 0;
            lastp = 0;
            cap = 0;
            retr = 0;
         end
         a = pa[$urandom_range(6)];
         rd = 1'($urandom_range(1));
         d = 8'($urandom());
         vv = video_levels_s'(6'($urandom()));
         cc = ctrl_mirror_s'(5'($urandom()));
         @(posedge clk);
         vid <= vv;
         ctl <= cc;
         exp = 8'h00;
         if (rd && a == ADDR_VIDEO_SIGNAL_STATUS) begin
            exp = {vv.intensity, vv.red, vv.green, vv.blue, vv.vsync, PEN_UNDEFINED, 1'(retr)};
            retr = 1 - retr;
         end
         if (rd && a == ADDR_MIRROR_WRITE_STATUS) begin
            exp = {vv.blank, cc, 1'(flag), 1'(lastp)};
         end
         if (rd && a == ADDR_CAPTURED_WRITE_BYTE) begin
            exp = 8'(cap);
            flag = 0;
         end
         if (!rd && (a == ADDR_CTRL_INDEX || a == ADDR_CTRL_DATA)) begin
            flag = 1;
            lastp = a[0];
            cap = d;
         end
         u_vstat_host.io_cycle(a, rd, d);
         #1;
         check("rvalid", {7'h00, rvalid}, {7'h00, rd});
         check("rdata", rdata, exp);
      end
      tally_and_finish();
   end
endmodule : video_status_write_monitor_tb_top
